// *** hw/dtc_map.vh ***
// Register map, field positions and reset values for the dual timer block
`ifndef DTC_MAP_VH
`define DTC_MAP_VH

// ****************************************
// Register addresses
// ****************************************
`define DTC_ADDR_CTRL 8'h88
`define DTC_ADDR_MODE 8'h89
`define DTC_ADDR_T0L 8'h8A
`define DTC_ADDR_T1L 8'h8B
`define DTC_ADDR_T0H 8'h8C
`define DTC_ADDR_T1H 8'h8D

// ****************************************
// Reset values
// ****************************************
`define DTC_RST_BYTE 8'h00

// ****************************************
// Control register bits
// ****************************************
`define DTC_C_TF1 7
`define DTC_C_TR1 6
`define DTC_C_TF0 5
`define DTC_C_TR0 4
`define DTC_C_IE1 3
`define DTC_C_IT1 2
`define DTC_C_IE0 1
`define DTC_C_IT0 0

// ****************************************
// Mode register bits
// ****************************************
`define DTC_M_GATE1 7
`define DTC_M_CT1 6
`define DTC_M_MODE1_HI 5
`define DTC_M_MODE1_LO 4
`define DTC_M_GATE0 3
`define DTC_M_CT0 2
`define DTC_M_MODE0_HI 1
`define DTC_M_MODE0_LO 0

// ****************************************
// Mode field codes
// ****************************************
`define DTC_MODE_13BIT 2'b00
`define DTC_MODE_16BIT 2'b01
`define DTC_MODE_RELOAD 2'b10
`define DTC_MODE_SPLIT 2'b11

// ****************************************
// Prescaler top and masks
// ****************************************
`define DTC_PRE_TOP 8'h1F
`define DTC_PRE_MASK 8'h1F
`define DTC_BYTE_TOP 8'hFF
`define DTC_BYTE_ONE 8'h01

`endif

// *** hw/dtc_timer_pair.v ***
// Dual 8-bit-pair timer/counter with external interrupt flag capture
`timescale 1ns/10ps
`include "dtc_map.vh"

module dtc_timer_pair
(
  input wire clk_i,
  input wire reset_n_i,
  input wire clk_en_i,
  input wire [7:0] sfr_addr_i,
  input wire [7:0] sfr_wdata_i,
  input wire sfr_wr_i,
  input wire sfr_bit_wr_i,
  input wire [2:0] sfr_bit_sel_i,
  input wire sfr_bit_val_i,
  output reg [7:0] sfr_rdata_o,
  output wire sfr_hit_o,
  input wire first_count_input_pin_i,
  input wire second_count_input_pin_i,
  input wire ext_irq_zero_pin_i,
  input wire ext_irq_one_pin_i,
  input wire first_timer_vector_i,
  input wire second_timer_vector_i,
  input wire ext_irq_zero_vector_i,
  input wire ext_irq_one_vector_i,
  output wire first_timer_overflow_flag_o,
  output wire second_timer_overflow_flag_o,
  output wire ext_irq_zero_flag_o,
  output wire ext_irq_one_flag_o,
  output wire [7:0] timer_mode_select_o
);

  // ****************************************
  // Increment helper with carry out
  // ****************************************
  // Returns {carry, byte+1}
  function [8:0] inc8;
    input [7:0] val;
    begin
      inc8 = {1'b0, val} + 9'h001;
    end
  endfunction

  // ****************************************
  // State
  // ****************************************
  reg [7:0] ctrl_r; // Control and flags
  reg [7:0] mode_r; // Mode select
  reg [7:0] t0l_r; // First timer low byte
  reg [7:0] t0h_r; // First timer high byte
  reg [7:0] t1l_r; // Second timer low byte
  reg [7:0] t1h_r; // Second timer high byte
  reg cnt0_smp_r; // Previous count input sample, first
  reg cnt1_smp_r; // Previous count input sample, second
  reg irq0_smp_r; // Previous irq pin sample, zero
  reg irq1_smp_r; // Previous irq pin sample, one

  reg [7:0] ctrl_nxt;
  reg [7:0] t0l_nxt;
  reg [7:0] t0h_nxt;
  reg [7:0] t1l_nxt;
  reg [7:0] t1h_nxt;
  reg ovf0; // First timer overflow event
  reg ovf1; // Second timer overflow event
  reg [8:0] sum_l;
  reg [8:0] sum_h;

  // ****************************************
  // Address decode
  // ****************************************
  wire hit_ctrl = (sfr_addr_i == `DTC_ADDR_CTRL);
  wire hit_mode = (sfr_addr_i == `DTC_ADDR_MODE);
  wire hit_t0l = (sfr_addr_i == `DTC_ADDR_T0L);
  wire hit_t1l = (sfr_addr_i == `DTC_ADDR_T1L);
  wire hit_t0h = (sfr_addr_i == `DTC_ADDR_T0H);
  wire hit_t1h = (sfr_addr_i == `DTC_ADDR_T1H);
  assign sfr_hit_o = hit_ctrl | hit_mode | hit_t0l | hit_t1l | hit_t0h | hit_t1h;

  // Byte writes reach all six registers
  wire wr_byte = sfr_wr_i & clk_en_i;
  // bit writes reach only the control register
  wire wr_cbit = sfr_bit_wr_i & clk_en_i & hit_ctrl;

  // ****************************************
  // Field extraction
  // ****************************************
  wire [1:0] mode0 = {mode_r[`DTC_M_MODE0_HI], mode_r[`DTC_M_MODE0_LO]};
  wire [1:0] mode1 = {mode_r[`DTC_M_MODE1_HI], mode_r[`DTC_M_MODE1_LO]};
  wire tr0 = ctrl_r[`DTC_C_TR0];
  wire tr1 = ctrl_r[`DTC_C_TR1];
  wire split0 = (mode0 == `DTC_MODE_SPLIT);

  // ****************************************
  // Count pulse sources
  // ****************************************
  // high sample then low sample
  wire edge0 = cnt0_smp_r & ~first_count_input_pin_i;
  wire edge1 = cnt1_smp_r & ~second_count_input_pin_i;
  // gate needs run and pin high
  wire run0 = tr0 & (~mode_r[`DTC_M_GATE0] | ext_irq_zero_pin_i);
  wire run1 = tr1 & (~mode_r[`DTC_M_GATE1] | ext_irq_one_pin_i);
  wire tick0 = run0 & (mode_r[`DTC_M_CT0] ? edge0 : 1'b1);
  wire tick1 = run1 & (mode_r[`DTC_M_CT1] ? edge1 : 1'b1);
  // split high byte counts cycles under second run bit
  wire tick0h = split0 & tr1;
  // second timer stopped in its mode 11
  wire tick1_go = tick1 & (mode1 != `DTC_MODE_SPLIT);

  // ****************************************
  // Pin edge samplers
  // ****************************************
  // Previous samples for falling edge detection
  always @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      cnt0_smp_r <= 1'b0;
      cnt1_smp_r <= 1'b0;
      irq0_smp_r <= 1'b0;
      irq1_smp_r <= 1'b0;
    end
    else if (clk_en_i)
    begin
      cnt0_smp_r <= first_count_input_pin_i;
      cnt1_smp_r <= second_count_input_pin_i;
      irq0_smp_r <= ext_irq_zero_pin_i;
      irq1_smp_r <= ext_irq_one_pin_i;
    end
  end

  // ****************************************
  // Count next-state
  // ****************************************
  always @*
  begin
    t0l_nxt = t0l_r;
    t0h_nxt = t0h_r;
    t1l_nxt = t1l_r;
    t1h_nxt = t1h_r;
    ovf0 = 1'b0;
    ovf1 = 1'b0;
    sum_l = 9'h000;
    sum_h = 9'h000;
    // Software byte writes first; counting overrides below
    if (wr_byte & hit_t0l)
      t0l_nxt = sfr_wdata_i;
    if (wr_byte & hit_t0h)
      t0h_nxt = sfr_wdata_i;
    if (wr_byte & hit_t1l)
      t1l_nxt = sfr_wdata_i;
    if (wr_byte & hit_t1h)
      t1h_nxt = sfr_wdata_i;
    // First timer
    if (tick0)
    begin
      case (mode0)
        `DTC_MODE_13BIT:
        begin
          t0l_nxt = (t0l_r & ~`DTC_PRE_MASK) | ((t0l_r + `DTC_BYTE_ONE) & `DTC_PRE_MASK);
          if ((t0l_r & `DTC_PRE_MASK) == `DTC_PRE_TOP)
          begin
            sum_h = inc8(t0h_r);
            t0h_nxt = sum_h[7:0];
            ovf0 = sum_h[8];
          end
        end
        `DTC_MODE_16BIT:
        begin
          sum_l = inc8(t0l_r);
          t0l_nxt = sum_l[7:0];
          if (sum_l[8])
          begin
            sum_h = inc8(t0h_r);
            t0h_nxt = sum_h[7:0];
            ovf0 = sum_h[8];
          end
        end
        `DTC_MODE_RELOAD:
        begin
          sum_l = inc8(t0l_r);
          t0l_nxt = sum_l[8] ? t0h_r : sum_l[7:0];
          ovf0 = sum_l[8];
        end
        // split: low byte is own 8-bit counter
        `DTC_MODE_SPLIT:
        begin
          sum_l = inc8(t0l_r);
          t0l_nxt = sum_l[7:0];
          ovf0 = sum_l[8];
        end
        default:
        begin
          t0l_nxt = t0l_r;
        end
      endcase
    end
    // split high byte, overflow goes to second flag; a second-timer count below that assigns ovf1 in the same cycle overrides it
    if (tick0h)
    begin
      t0h_nxt = t0h_r + `DTC_BYTE_ONE;
      ovf1 = (t0h_r == `DTC_BYTE_TOP);
    end
    // Second timer
    if (tick1_go)
    begin
      case (mode1)
        `DTC_MODE_13BIT:
        begin
          t1l_nxt = (t1l_r & ~`DTC_PRE_MASK) | ((t1l_r + `DTC_BYTE_ONE) & `DTC_PRE_MASK);
          if ((t1l_r & `DTC_PRE_MASK) == `DTC_PRE_TOP)
          begin
            t1h_nxt = t1h_r + `DTC_BYTE_ONE;
            ovf1 = ~split0 & (t1h_r == `DTC_BYTE_TOP);
          end
        end
        `DTC_MODE_16BIT:
        begin
          t1l_nxt = t1l_r + `DTC_BYTE_ONE;
          if (t1l_r == `DTC_BYTE_TOP)
          begin
            t1h_nxt = t1h_r + `DTC_BYTE_ONE;
            ovf1 = ~split0 & (t1h_r == `DTC_BYTE_TOP);
          end
        end
        `DTC_MODE_RELOAD:
        begin
          t1l_nxt = (t1l_r == `DTC_BYTE_TOP) ? t1h_r : t1l_r + `DTC_BYTE_ONE;
          ovf1 = ~split0 & (t1l_r == `DTC_BYTE_TOP);
        end
        default:
        begin
          t1l_nxt = t1l_r;
        end
      endcase
    end
  end

  // ****************************************
  // Control register next-state
  // ****************************************
  always @*
  begin
    ctrl_nxt = ctrl_r;
    // software writes run, type and flag bits
    if (wr_byte & hit_ctrl)
      ctrl_nxt = sfr_wdata_i;
    else if (wr_cbit)
      ctrl_nxt[sfr_bit_sel_i] = sfr_bit_val_i;
    if (first_timer_vector_i)
      ctrl_nxt[`DTC_C_TF0] = 1'b0;
    if (second_timer_vector_i)
      ctrl_nxt[`DTC_C_TF1] = 1'b0;
    if (ext_irq_zero_vector_i & ctrl_r[`DTC_C_IT0])
      ctrl_nxt[`DTC_C_IE0] = 1'b0;
    if (ext_irq_one_vector_i & ctrl_r[`DTC_C_IT1])
      ctrl_nxt[`DTC_C_IE1] = 1'b0;
    if (ovf0)
      ctrl_nxt[`DTC_C_TF0] = 1'b1;
    if (ovf1)
      ctrl_nxt[`DTC_C_TF1] = 1'b1;
    // edge or level sets external flags
    if (ctrl_r[`DTC_C_IT0])
    begin
      if (irq0_smp_r & ~ext_irq_zero_pin_i)
        ctrl_nxt[`DTC_C_IE0] = 1'b1;
    end
    else
    begin
      ctrl_nxt[`DTC_C_IE0] = ~ext_irq_zero_pin_i;
    end
    if (ctrl_r[`DTC_C_IT1])
    begin
      if (irq1_smp_r & ~ext_irq_one_pin_i)
        ctrl_nxt[`DTC_C_IE1] = 1'b1;
    end
    else
    begin
      ctrl_nxt[`DTC_C_IE1] = ~ext_irq_one_pin_i;
    end
  end

  // ****************************************
  // Register update
  // ****************************************
  // all registers reset to zero
  always @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      ctrl_r <= `DTC_RST_BYTE;
      mode_r <= `DTC_RST_BYTE;
      t0l_r <= `DTC_RST_BYTE;
      t0h_r <= `DTC_RST_BYTE;
      t1l_r <= `DTC_RST_BYTE;
      t1h_r <= `DTC_RST_BYTE;
    end
    else if (clk_en_i)
    begin
      ctrl_r <= ctrl_nxt;
      if (wr_byte & hit_mode)
        mode_r <= sfr_wdata_i;
      t0l_r <= t0l_nxt;
      t0h_r <= t0h_nxt;
      t1l_r <= t1l_nxt;
      t1h_r <= t1h_nxt;
    end
  end

  // ****************************************
  // Read mux
  // ****************************************
  // Registered read data for the addressed byte
  always @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      sfr_rdata_o <= `DTC_RST_BYTE;
    else if (clk_en_i)
    begin
      case (sfr_addr_i)
        `DTC_ADDR_CTRL: sfr_rdata_o <= ctrl_r;
        `DTC_ADDR_MODE: sfr_rdata_o <= mode_r;
        `DTC_ADDR_T0L: sfr_rdata_o <= t0l_r;
        `DTC_ADDR_T1L: sfr_rdata_o <= t1l_r;
        `DTC_ADDR_T0H: sfr_rdata_o <= t0h_r;
        `DTC_ADDR_T1H: sfr_rdata_o <= t1h_r;
        default: sfr_rdata_o <= `DTC_RST_BYTE;
      endcase
    end
  end

  // Flag outputs straight from the control register
  assign first_timer_overflow_flag_o = ctrl_r[`DTC_C_TF0];
  assign second_timer_overflow_flag_o = ctrl_r[`DTC_C_TF1];
  assign ext_irq_zero_flag_o = ctrl_r[`DTC_C_IE0];
  assign ext_irq_one_flag_o = ctrl_r[`DTC_C_IE1];
  assign timer_mode_select_o = mode_r;

endmodule // dtc_timer_pair

// *** verif/dtc_timer_pair_props.sv ***
// Port-level concurrent checks for the dual timer block
`timescale 1ns/10ps
module dtc_timer_pair_props
(
  input wire clk_i,
  input wire reset_n_i,
  input wire clk_en_i,
  input wire [7:0] sfr_addr_i,
  input wire [7:0] sfr_wdata_i,
  input wire sfr_wr_i,
  input wire sfr_bit_wr_i,
  input wire [7:0] sfr_rdata_o,
  input wire sfr_hit_o,
  input wire ext_irq_zero_pin_i,
  input wire ext_irq_one_pin_i,
  input wire first_timer_vector_i,
  input wire second_timer_vector_i,
  input wire ext_irq_one_vector_i,
  input wire first_timer_overflow_flag_o,
  input wire second_timer_overflow_flag_o,
  input wire ext_irq_zero_flag_o,
  input wire ext_irq_one_flag_o,
  input wire [7:0] timer_mode_select_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  // Mode register write and read requests
  sequence s_mode_wr;
    clk_en_i && sfr_wr_i && sfr_addr_i == 8'h89;
  endsequence
  sequence s_mode_rd;
    clk_en_i && !sfr_wr_i && sfr_addr_i == 8'h89;
  endsequence
  property p_rst_clear;
    $rose(reset_n_i) |-> timer_mode_select_o == 8'h00 && !first_timer_overflow_flag_o;
  endproperty
  a_rst_clear: assert property (p_rst_clear) else $error("state not clear after reset");
  property p_mode_wr;
    s_mode_wr |=> timer_mode_select_o == $past(sfr_wdata_i);
  endproperty
  a_mode_wr: assert property (p_mode_wr) else $error("mode write lost");
  property p_mode_nobit;
    clk_en_i && sfr_bit_wr_i && !sfr_wr_i |=> $stable(timer_mode_select_o);
  endproperty
  a_mode_nobit: assert property (p_mode_nobit) else $error("mode changed by bit write");
  property p_mode_rd;
    s_mode_rd |=> sfr_rdata_o == $past(timer_mode_select_o);
  endproperty
  a_mode_rd: assert property (p_mode_rd) else $error("mode read mismatch");
  property p_tf0_fall;
    $fell(first_timer_overflow_flag_o) |-> $past(first_timer_vector_i || sfr_wr_i || sfr_bit_wr_i);
  endproperty
  a_tf0_fall: assert property (p_tf0_fall) else $error("first overflow flag lost");
  property p_tf1_fall;
    $fell(second_timer_overflow_flag_o) |-> $past(second_timer_vector_i || sfr_wr_i || sfr_bit_wr_i);
  endproperty
  a_tf1_fall: assert property (p_tf1_fall) else $error("second overflow flag lost");
  property p_ie0_rise;
    $rose(ext_irq_zero_flag_o) |-> !$past(ext_irq_zero_pin_i) || !$past(ext_irq_zero_pin_i, 2)
      || $past(sfr_wr_i || sfr_bit_wr_i);
  endproperty
  a_ie0_rise: assert property (p_ie0_rise) else $error("irq zero flag without low pin");
  property p_ie1_fall;
    $fell(ext_irq_one_flag_o) |-> $past(ext_irq_one_vector_i || ext_irq_one_pin_i || sfr_wr_i
      || sfr_bit_wr_i);
  endproperty
  a_ie1_fall: assert property (p_ie1_fall) else $error("irq one flag dropped");
  property p_unmapped;
    clk_en_i && !sfr_hit_o |=> sfr_rdata_o == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
endmodule // dtc_timer_pair_props
bind dtc_timer_pair dtc_timer_pair_props u_props (.*);

// *** verif/dtc_core_model.sv ***
// Processor core model driving the register bus and vector pulses
`timescale 1ns/10ps
module dtc_core_model
(
  input wire clk_i,
  input wire [7:0] rdata_i,
  output reg [7:0] addr_o,
  output reg [7:0] wdata_o,
  output reg wr_o,
  output reg bit_wr_o,
  output reg [2:0] bit_sel_o,
  output reg bit_val_o,
  output reg [3:0] vec_o
);
  initial
  begin
    addr_o = 8'h00;
    wdata_o = 8'h00;
    wr_o = 1'b0;
    bit_wr_o = 1'b0;
    bit_sel_o = 3'h0;
    bit_val_o = 1'b0;
    vec_o = 4'h0;
  end
  // Byte write, data scrambled once released
  task wr_byte(input [7:0] a, input [7:0] d);
    begin
      @(posedge clk_i);
      addr_o <= a;
      wdata_o <= d;
      wr_o <= 1'b1;
      @(posedge clk_i);
      wr_o <= 1'b0;
      wdata_o <= ~d;
    end
  endtask
  task wr_bit(input [2:0] s, input v);
    begin
      @(posedge clk_i);
      addr_o <= 8'h88;
      bit_sel_o <= s;
      bit_val_o <= v;
      bit_wr_o <= 1'b1;
      @(posedge clk_i);
      bit_wr_o <= 1'b0;
      bit_val_o <= ~v;
    end
  endtask
  // Read data valid one cycle after address
  task rd_byte(input [7:0] a, output [7:0] d);
    begin
      @(posedge clk_i);
      addr_o <= a;
      @(posedge clk_i);
      #1 d = rdata_i;
    end
  endtask
  // One-cycle vector pulse
  task vector(input [1:0] n);
    begin
      @(posedge clk_i);
      vec_o[n] <= 1'b1;
      @(posedge clk_i);
      vec_o <= 4'h0;
    end
  endtask
endmodule // dtc_core_model

// *** verif/dtc_timer_pair_tb_top.sv ***
// Self-checking bench for the dual timer block
`timescale 1ns/10ps
module dtc_timer_pair_tb_top;
  reg clk_i = 1'b0;
  reg reset_n_i = 1'b0;
  reg clk_en = 1'b1;
  reg [1:0] cnt_pin = 2'b00;
  reg [1:0] irq_pin = 2'b11;
  wire [7:0] rdata, addr, wdata, mode;
  wire wr, bwr, bval, hit;
  wire [2:0] bsel;
  wire [3:0] vec;
  wire [3:0] flg;
  integer err_total = 0;
  integer samples_checked = 0;
  integer k, m;
  reg [7:0] rd_v;
  initial forever #5 clk_i = ~clk_i;
  dtc_core_model core (.clk_i(clk_i), .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata),
    .wr_o(wr), .bit_wr_o(bwr), .bit_sel_o(bsel), .bit_val_o(bval), .vec_o(vec));
  dtc_timer_pair DUT (.clk_i(clk_i), .reset_n_i(reset_n_i), .clk_en_i(clk_en),
    .sfr_addr_i(addr), .sfr_wdata_i(wdata), .sfr_wr_i(wr), .sfr_bit_wr_i(bwr),
    .sfr_bit_sel_i(bsel), .sfr_bit_val_i(bval), .sfr_rdata_o(rdata), .sfr_hit_o(hit),
    .first_count_input_pin_i(cnt_pin[0]), .second_count_input_pin_i(cnt_pin[1]),
    .ext_irq_zero_pin_i(irq_pin[0]), .ext_irq_one_pin_i(irq_pin[1]),
    .first_timer_vector_i(vec[0]), .second_timer_vector_i(vec[1]),
    .ext_irq_zero_vector_i(vec[2]), .ext_irq_one_vector_i(vec[3]),
    .first_timer_overflow_flag_o(flg[0]), .second_timer_overflow_flag_o(flg[1]),
    .ext_irq_zero_flag_o(flg[2]), .ext_irq_one_flag_o(flg[3]), .timer_mode_select_o(mode));
  task check(input [7:0] seen, input [7:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (seen !== exp)
      begin
        err_total = err_total + 1;
        $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  task rchk(input [7:0] a, input [7:0] exp);
    begin
      core.rd_byte(a, rd_v);
      check(rd_v, exp);
    end
  endtask
  // Full-rate pulses, each level held one cycle
  task pulses(input integer n, input integer p);
    begin
      repeat (n)
      begin
        @(posedge clk_i) cnt_pin[p] <= 1'b1;
        @(posedge clk_i) cnt_pin[p] <= 1'b0;
      end
    end
  endtask
  task close_out;
    begin
      $display("checks %0d errors %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask
  initial
  begin
    repeat (20000) @(posedge clk_i);
    err_total = err_total + 1;
    close_out;
  end
  initial
  begin
    repeat (10) @(posedge clk_i);
    reset_n_i <= 1'b1;
    for (k = 8'h88; k < 8'h8E; k = k + 1)
      rchk(k, 8'h00);
    rchk(8'h90, 8'h00);
    check(hit, 1'b0);
    core.wr_byte(8'h89, 8'hA5);
    core.wr_bit(3'h1, 1'b0);
    rchk(8'h89, 8'hA5);
    check(hit, 1'b1);
    $display("registers done");
    for (k = 0; k < 2; k = k + 1)
      for (m = 0; m < 3; m = m + 1)
      begin
        core.wr_byte(8'h89, m << (4 * k));
        core.wr_byte(8'h8C + k, (m == 2) ? 8'h80 : 8'hFF);
        core.wr_byte(8'h8A + k, (m == 0) ? 8'h1E : 8'hFE);
        core.wr_bit(4 + 2 * k, 1'b1);
        repeat (6) @(posedge clk_i);
        core.wr_bit(4 + 2 * k, 1'b0);
        rchk(8'h8C + k, (m == 2) ? 8'h80 : 8'h00);
        rchk(8'h8A + k, (m == 2) ? 8'h86 : 8'h06);
        core.rd_byte(8'h8A + k, rd_v);
        check(rd_v[7:4], (m == 2) ? 4'h8 : 4'h0);
        check(flg[k], 1'b1);
        core.vector(k);
        #1 check(flg[k], 1'b0);
      end
    $display("modes done");
    core.wr_byte(8'h89, 8'h30);
    core.wr_byte(8'h8B, 8'h55);
    core.wr_bit(3'h6, 1'b1);
    repeat (5) @(posedge clk_i);
    rchk(8'h8B, 8'h55);
    core.wr_bit(3'h6, 1'b0);
    core.wr_byte(8'h89, 8'h03);
    core.wr_byte(8'h8A, 8'hFE);
    core.wr_byte(8'h8C, 8'hFE);
    core.wr_byte(8'h88, 8'h50);
    repeat (6) @(posedge clk_i);
    #1 check(flg[0], 1'b1);
    check(flg[1], 1'b1);
    core.wr_byte(8'h88, 8'h00);
    rchk(8'h8A, 8'h06);
    rchk(8'h8C, 8'h06);
    core.wr_byte(8'h89, 8'h01);
    core.wr_byte(8'h8A, 8'h10);
    core.wr_bit(3'h4, 1'b1);
    @(posedge clk_i) clk_en <= 1'b0;
    repeat (4) @(posedge clk_i);
    @(posedge clk_i) clk_en <= 1'b1;
    core.wr_bit(3'h4, 1'b0);
    rchk(8'h8A, 8'h13);
    for (k = 0; k < 2; k = k + 1)
    begin
      core.wr_byte(8'h89, 8'h0D << (4 * k));
      core.wr_byte(8'h8A + k, 8'h00);
      @(posedge clk_i) irq_pin[k] <= 1'b0;
      core.wr_bit(4 + 2 * k, 1'b1);
      pulses(3, k);
      @(posedge clk_i) irq_pin[k] <= 1'b1;
      pulses(3, k);
      core.wr_bit(4 + 2 * k, 1'b0);
      rchk(8'h8A + k, 8'h03);
    end
    $display("counter done");
    for (k = 0; k < 2; k = k + 1)
    begin
      core.wr_bit(2 * k, 1'b1);
      @(posedge clk_i) irq_pin[k] <= 1'b0;
      @(posedge clk_i) irq_pin[k] <= 1'b1;
      repeat (2) @(posedge clk_i);
      #1 check(flg[2 + k], 1'b1);
      core.vector(2 + k);
      #1 check(flg[2 + k], 1'b0);
      core.wr_bit(2 * k, 1'b0);
      @(posedge clk_i) irq_pin[k] <= 1'b0;
      repeat (2) @(posedge clk_i);
      core.vector(2 + k);
      #1 check(flg[2 + k], 1'b1);
      @(posedge clk_i) irq_pin[k] <= 1'b1;
      repeat (2) @(posedge clk_i);
      #1 check(flg[2 + k], 1'b0);
    end
    $display("irq done");
    close_out;
  end
endmodule // dtc_timer_pair_tb_top
